// ### verilog/srhr_pkg.sv
/*
  Shared constants for the setpoint ramp and heater range block: register
  offsets, field positions, reset values, timing counts, range and mode
  encodings, and the ramp step and range scaling arithmetic.
  Assumes a 10 MHz system clock and an APB register bus with 32-bit data.
*/
package srhr_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_MS       = 600;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned BYPASS_HOLD_S = 3;
  localparam int unsigned BYPASS_CYCLES = CLK_HZ * BYPASS_HOLD_S;

  // Rate in 0.1 deg/min, setpoint in 0.0001 deg; 600 ms tick => 10 units
  localparam logic [9:0]  RATE_MAX      = 10'h3e8;
  localparam logic [31:0] STEP_PER_RATE = 32'h0000000a;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [3:0] CHAN_FIRST = 4'h1;
  localparam logic [3:0] CHAN_LAST  = 4'h4;
  localparam logic [3:0] TGT_OFS    = 4'h0;
  localparam logic [3:0] RCFG_OFS   = 4'h4;
  localparam logic [3:0] OCFG_OFS   = 4'h8;
  localparam logic [3:0] EFF_OFS    = 4'hc;

  // Field positions
  localparam int unsigned CTRL_ALLOFF_BIT = 0;
  localparam int unsigned CTRL_PUEN_BIT   = 1;
  localparam int unsigned RCFG_RATE_LSB   = 0;
  localparam int unsigned RCFG_EN_BIT     = 16;
  localparam int unsigned RCFG_BUSY_BIT   = 31;
  localparam int unsigned OCFG_RANGE_LSB  = 0;
  localparam int unsigned OCFG_MODE_LSB   = 4;
  localparam int unsigned OCFG_SUNITS_BIT = 8;
  localparam int unsigned OCFG_CLOSED_BIT = 9;
  localparam int unsigned OCFG_STOP_BIT   = 12;
  localparam int unsigned OCFG_BYP_BIT    = 13;
  localparam int unsigned OCFG_MAN_LSB    = 16;

  // Reset values
  localparam logic [9:0]  RST_RATE = 10'h000;
  localparam logic [31:0] RST_SP   = 32'h00000000;
  localparam logic [15:0] RST_MAN  = 16'h0000;
  localparam logic [15:0] DAC_MID  = 16'h8000;

  typedef enum logic [1:0] {
    RANGE_OFF  = 2'b00,
    RANGE_LOW  = 2'b01,
    RANGE_MED  = 2'b10,
    RANGE_HIGH = 2'b11
  } srhr_range_e;

  typedef enum logic [1:0] {
    MODE_OPEN = 2'b00,
    MODE_WARM = 2'b01,
    MODE_MON  = 2'b10
  } srhr_mode_e;

  // Setpoint movement for one tick at the given rate
  function automatic logic [31:0] ramp_step(input logic [9:0] rate);
    ramp_step = 32'({22'h0, rate} * STEP_PER_RATE);
  endfunction

  // Decade power scaling of a heater drive by range
  function automatic logic [15:0] range_scale(input logic [15:0] drv,
                                              input logic [1:0]  rng);
    case (rng)
      RANGE_HIGH: range_scale = drv;
      RANGE_MED:  range_scale = drv / 16'h000a;
      RANGE_LOW:  range_scale = drv / 16'h0064;
      default:    range_scale = 16'h0000;
    endcase
  endfunction

endpackage

// ### verilog/srhr_ramp_chan.sv
/*
  One setpoint ramp engine: holds the ramp target and the effective
  setpoint of one control output and walks it on each update tick.
  Assumes one-cycle request pulses from the register block and a
  one-cycle tick from a divider in the same clock domain.
*/
`timescale 1ns/1ns
module srhr_ramp_chan (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Controls
  input  wire logic        tick,
  input  wire logic        ramp_en,
  input  wire logic        sensor_units,
  input  wire logic [9:0]  rate,
  input  wire logic        abort,
  // Requests
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  input  wire logic        stop,
  input  wire logic        bypass,
  input  wire logic [31:0] measured,
  // State
  output logic      [31:0] eff_sp,
  output logic             busy
);

  logic [31:0] tgt_reg;
  logic [31:0] step;
  logic [31:0] gap;
  logic        up;

  // Direction from target against the present setpoint, rate is magnitude
  // R3 direction from target
  always_comb begin
    step = srhr_pkg::ramp_step(rate);
    up   = tgt_reg > eff_sp;
    gap  = up ? tgt_reg - eff_sp : eff_sp - tgt_reg;
  end

  // Requests first, then the tick walk; bypass beats a fresh load
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eff_sp  <= srhr_pkg::RST_SP;
      tgt_reg <= srhr_pkg::RST_SP;
      busy    <= 1'b0;
    end else if (bypass) begin
      // R7 load measured value
      eff_sp  <= measured;
      tgt_reg <= measured;
      busy    <= 1'b0;
    end else if (load) begin
      tgt_reg <= load_val;
      // R2 new target ramps
      // R4 sensor units direct
      if (ramp_en && !sensor_units) begin
        busy <= load_val != eff_sp;
      end else begin
        eff_sp <= load_val;
        busy   <= 1'b0;
      end
    end else if (stop) begin
      // R9 freeze in place
      tgt_reg <= eff_sp;
      busy    <= 1'b0;
    end else if (!ramp_en || abort) begin
      // R5 keep intermediate value
      busy <= 1'b0;
      // R21 zero rate
    end else if (tick && busy && step != 32'h0) begin
      // R20 step and clamp
      if (gap <= step) begin
        eff_sp <= tgt_reg;
        busy   <= 1'b0;
      end else if (up) begin
        eff_sp <= eff_sp + step;
      end else begin
        eff_sp <= eff_sp - step;
      end
    end
  end

  rate_zero_a: assert property ( // R21
    @(posedge clk) disable iff (!arst_n)
    busy && rate == 10'h000 && !load && !bypass && ramp_en
      |=> $stable(eff_sp))
    else $error("setpoint moved at zero rate");

  step_clamp_a: assert property ( // R20
    @(posedge clk) disable iff (!arst_n)
    tick && busy && ramp_en && !abort && !load && !stop && !bypass
      && step != 32'h0 && gap <= step
      |=> eff_sp == $past(tgt_reg) && !busy)
    else $error("ramp did not clamp at target");

  direct_load_a: assert property ( // R4
    @(posedge clk) disable iff (!arst_n)
    load && !bypass && sensor_units |=> eff_sp == $past(load_val) && !busy)
    else $error("sensor unit setpoint not loaded directly");

  bypass_load_a: assert property ( // R7
    @(posedge clk) disable iff (!arst_n)
    bypass |=> eff_sp == $past(measured) && !busy)
    else $error("bypass did not load measured value");

  stop_hold_a: assert property ( // R9
    @(posedge clk) disable iff (!arst_n)
    stop && !load && !bypass |=> !busy && $stable(eff_sp))
    else $error("stopped ramp kept moving");

endmodule // srhr_ramp_chan

// ### verilog/srhr_top.sv
/*
  Setpoint ramp and heater range control for four control outputs, with
  an APB register slave, ramp engines, range shutdown logic, heater drive
  scaling for outputs one and two and converter codes for three and four.
  Assumes synchronous inputs from sensor, keypad and supply logic, one
  10 MHz clock and an APB master that holds each request until pready.
*/
// The APB slave port and the placing of the registers were left to the implementer.
// Summary of operation
// R1 - Ramp rate 0 to 100 deg/min in 0.1 steps, held fixed point.
// R2 - With ramping on in temperature units, a new target starts a ramp.
// R3 - Rate is a magnitude; direction comes from target versus setpoint.
// R4 - In sensor units ramp enable is kept but setpoints load directly.
// R5 - Turning ramping off mid ramp keeps the intermediate setpoint.
// R6 - Input type or curve change mid ramp stops ramping, range off.
// R7 - Setpoint key held three seconds loads measured value, no ramp.
// R8 - Each output has a ramp enable, off after reset.
// R9 - Stop freezes the setpoint, ramping stays on; new entry ramps again.
// R10 - Heaters one and two: off, low, medium, high in decade steps.
// R11 - Analog outputs three and four offer only off or on.
// R12 - Limit, input setup change, power loss, input error force off; power loss does so only while power-up enable is off.
// R13 - Every range setting is off after reset.
// R14 - All-off sets every output range to off at once.
// R15 - All-off ignores keypad lock and remote mode.
// R16 - Analog outputs use a 16-bit bipolar code, -10 V to +10 V.
// R17 - Analog modes: open loop, warm-up supply, monitor.
// R18 - Host starts ramps and reads ramp-in-progress per output.
// R19 - Closed loop adds manual drive to loop result; open loop uses it.
// R20 - Each tick moves setpoint by rate step, clamps, clears busy.
// R21 - Zero rate holds the setpoint while busy stays set.
`timescale 1ns/1ns
module srhr_top #(
  parameter int unsigned TICK_CYCLES   = srhr_pkg::TICK_CYCLES,
  parameter int unsigned BYPASS_CYCLES = srhr_pkg::BYPASS_CYCLES
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // Sensor and fault inputs, one bit or word per output except the shared temp_limit and power_lost
  input  wire logic [127:0] measured,
  input  wire logic [3:0]   sensor_chg,
  input  wire logic [3:0]   input_err,
  input  wire logic         temp_limit,
  input  wire logic         power_lost,
  // Front panel
  input  wire logic         all_off_key,
  input  wire logic         target_temperature_cmd_key,
  input  wire logic         stop_key,
  input  wire logic [1:0]   shown_loop,
  // Loop results and analog sources
  input  wire logic [31:0]  pid_result,
  input  wire logic [31:0]  warmup_code,
  input  wire logic [31:0]  monitor_code,
  // Outputs
  output logic      [7:0]   range_out,
  output logic      [3:0]   ramp_busy,
  output logic      [31:0]  heater_drive,
  output logic      [31:0]  dac_code
);

  logic        pready_reg;
  logic [9:0]  rate_reg     [4];
  logic [3:0]  ramp_en_reg;
  logic [1:0]  range_reg    [4];
  logic [1:0]  mode_reg     [4];
  logic [3:0]  sunits_reg;
  logic [3:0]  closed_reg;
  logic [15:0] manual_drive_cmd_reg [4];
  logic        puen_reg;
  logic [31:0] eff_sp       [4];
  logic [3:0]  busy;
  logic [22:0] tick_cnt_reg;
  logic        tick_reg;
  logic [24:0] hold_cnt_reg;
  logic        hold_bypass_reg;
  logic        acc;
  logic        fire;
  logic        hit;
  logic        is_ctrl;
  logic [1:0]  cidx;
  logic [3:0]  roff;
  logic        wr;
  logic [3:0]  tgt_wr;
  logic [3:0]  rcfg_wr;
  logic [3:0]  ocfg_wr;
  logic        all_off;
  logic [3:0]  stop_req;
  logic [3:0]  bypass_req;
  logic [31:0] rd_data;
  logic [1:0]  range_next   [4];

  // APB decode; registers are word aligned in the low byte only
  always_comb begin
    acc     = psel && penable;
    fire    = acc && pready_reg;
    is_ctrl = paddr[7:0] == srhr_pkg::CTRL_OFS;
    roff    = paddr[3:0];
    cidx    = 2'(paddr[7:4] - srhr_pkg::CHAN_FIRST);
    hit     = paddr[31:8] == 24'h000000 && paddr[1:0] == 2'b00
              && (is_ctrl || (paddr[7:4] >= srhr_pkg::CHAN_FIRST
                              && paddr[7:4] <= srhr_pkg::CHAN_LAST));
    wr      = fire && pwrite && hit;
    for (int i = 0; i < 4; i++) begin
      tgt_wr[i]  = wr && !is_ctrl && cidx == 2'(i)
                   && roff == srhr_pkg::TGT_OFS;
      rcfg_wr[i] = wr && !is_ctrl && cidx == 2'(i)
                   && roff == srhr_pkg::RCFG_OFS;
      ocfg_wr[i] = wr && !is_ctrl && cidx == 2'(i)
                   && roff == srhr_pkg::OCFG_OFS;
    end
  end

  // Register read mux; ramp busy bit shows the engine's own state
  // R18 ramp status readback
  always_comb begin
    rd_data = 32'h00000000;
    if (is_ctrl) begin
      rd_data[srhr_pkg::CTRL_PUEN_BIT] = puen_reg;
    end else begin
      case (roff)
        srhr_pkg::RCFG_OFS: begin
          rd_data[srhr_pkg::RCFG_RATE_LSB +: 10] = rate_reg[cidx];
          rd_data[srhr_pkg::RCFG_EN_BIT]         = ramp_en_reg[cidx];
          rd_data[srhr_pkg::RCFG_BUSY_BIT]       = busy[cidx];
        end
        srhr_pkg::OCFG_OFS: begin
          rd_data[srhr_pkg::OCFG_RANGE_LSB +: 2]  = range_reg[cidx];
          rd_data[srhr_pkg::OCFG_MODE_LSB +: 2]   = mode_reg[cidx];
          rd_data[srhr_pkg::OCFG_SUNITS_BIT]      = sunits_reg[cidx];
          rd_data[srhr_pkg::OCFG_CLOSED_BIT]      = closed_reg[cidx];
          rd_data[srhr_pkg::OCFG_MAN_LSB +: 16]   =
            manual_drive_cmd_reg[cidx];
        end
        srhr_pkg::TGT_OFS, srhr_pkg::EFF_OFS: begin
          rd_data = eff_sp[cidx];
        end
        default: rd_data = 32'h00000000;
      endcase
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_reg <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h00000000;
    end else begin
      pready_reg <= acc && !pready_reg;
      pslverr    <= acc && !pready_reg && !hit;
      prdata     <= (acc && !pready_reg && !pwrite && hit) ? rd_data
                                                            : 32'h00000000;
    end
  end
  assign pready = pready_reg;

  // Ramp tick divider; a long tick keeps each step an exact integer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= 23'h000000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 23'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 23'h000000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 23'h000001;
      tick_reg     <= 1'b0;
    end
  end

  // Setpoint key hold timer, fires once per press
  // R7 three second hold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt_reg    <= 25'h0000000;
      hold_bypass_reg <= 1'b0;
    end else if (!target_temperature_cmd_key) begin
      hold_cnt_reg    <= 25'h0000000;
      hold_bypass_reg <= 1'b0;
    end else if (hold_cnt_reg == 25'(BYPASS_CYCLES - 1)) begin
      hold_cnt_reg    <= hold_cnt_reg + 25'h0000001;
      hold_bypass_reg <= 1'b1;
    end else begin
      hold_bypass_reg <= 1'b0;
      if (hold_cnt_reg < 25'(BYPASS_CYCLES)) begin
        hold_cnt_reg <= hold_cnt_reg + 25'h0000001;
      end
    end
  end

  // Request pulses from the bus and the panel
  // R15 all-off never gated
  always_comb begin
    all_off = all_off_key
              || (wr && is_ctrl && pwdata[srhr_pkg::CTRL_ALLOFF_BIT]);
    for (int i = 0; i < 4; i++) begin
      stop_req[i]   = (ocfg_wr[i] && pwdata[srhr_pkg::OCFG_STOP_BIT])
                      || (stop_key && shown_loop == 2'(i));
      bypass_req[i] = (ocfg_wr[i] && pwdata[srhr_pkg::OCFG_BYP_BIT])
                      || (hold_bypass_reg && shown_loop == 2'(i));
    end
  end

  // Control settings written by software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      puen_reg   <= 1'b0;
      sunits_reg <= 4'h0;
      closed_reg <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        rate_reg[i]             <= srhr_pkg::RST_RATE;
        mode_reg[i]             <= srhr_pkg::MODE_OPEN;
        manual_drive_cmd_reg[i] <= srhr_pkg::RST_MAN;
      end
    end else begin
      if (wr && is_ctrl) begin
        puen_reg <= pwdata[srhr_pkg::CTRL_PUEN_BIT];
      end
      for (int i = 0; i < 4; i++) begin
        // R1 rate clipped to 100.0
        if (rcfg_wr[i]) begin
          rate_reg[i] <= (pwdata[9:0] > srhr_pkg::RATE_MAX)
                         ? srhr_pkg::RATE_MAX : pwdata[9:0];
        end
        if (ocfg_wr[i]) begin
          mode_reg[i]   <= pwdata[srhr_pkg::OCFG_MODE_LSB +: 2];
          sunits_reg[i] <= pwdata[srhr_pkg::OCFG_SUNITS_BIT];
          closed_reg[i] <= pwdata[srhr_pkg::OCFG_CLOSED_BIT];
          manual_drive_cmd_reg[i] <= pwdata[srhr_pkg::OCFG_MAN_LSB +: 16];
        end
      end
    end
  end

  // Ramp enable; an input change mid ramp clears it ahead of a write
  // R8 ramp enable reset off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ramp_en_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // R6 abort ramping
        if (sensor_chg[i] && busy[i]) begin
          ramp_en_reg[i] <= 1'b0;
        end else if (rcfg_wr[i]) begin
          ramp_en_reg[i] <= pwdata[srhr_pkg::RCFG_EN_BIT];
        end
      end
    end
  end

  // Range next value: shutdowns beat a software write in the same cycle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      range_next[i] = range_reg[i];
      if (ocfg_wr[i]) begin
        // R11 analog outputs off or on
        if (i >= 2) begin
          range_next[i] = (pwdata[1:0] == srhr_pkg::RANGE_OFF)
                          ? srhr_pkg::RANGE_OFF : srhr_pkg::RANGE_LOW;
        end else begin
          // R10 heater decade ranges
          range_next[i] = pwdata[srhr_pkg::OCFG_RANGE_LSB +: 2];
        end
      end
      // R12 automatic shutdown
      // R6 heater off on change
      if (temp_limit || sensor_chg[i] || input_err[i]
          || (power_lost && !puen_reg)) begin
        range_next[i] = srhr_pkg::RANGE_OFF;
      end
      // R14 all outputs off
      if (all_off) begin
        range_next[i] = srhr_pkg::RANGE_OFF;
      end
    end
  end

  // Range registers
  // R13 ranges reset off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        range_reg[i] <= srhr_pkg::RANGE_OFF;
      end
      range_out <= 8'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        range_reg[i]           <= range_next[i];
        range_out[2*i +: 2]    <= range_next[i];
      end
    end
  end

  // Heater drive: manual alone in open loop, added to loop in closed loop
  // R19 manual drive use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      heater_drive <= 32'h00000000;
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic [16:0] sum;
        sum = {1'b0, pid_result[16*i +: 16]}
              + {1'b0, manual_drive_cmd_reg[i]};
        if (!closed_reg[i]) begin
          sum = {1'b0, manual_drive_cmd_reg[i]};
        end
        heater_drive[16*i +: 16] <= srhr_pkg::range_scale(
          sum[16] ? 16'hffff : sum[15:0], range_reg[i]);
      end
    end
  end

  // Analog converter codes; off parks at midscale, which is 0 V
  // R16 bipolar code
  // R17 analog mode select
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_code <= {srhr_pkg::DAC_MID, srhr_pkg::DAC_MID};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (range_reg[i+2] == srhr_pkg::RANGE_OFF) begin
          dac_code[16*i +: 16] <= srhr_pkg::DAC_MID;
        end else begin
          case (mode_reg[i+2])
            srhr_pkg::MODE_WARM:
              dac_code[16*i +: 16] <= warmup_code[16*i +: 16];
            srhr_pkg::MODE_MON:
              dac_code[16*i +: 16] <= monitor_code[16*i +: 16];
            default:
              dac_code[16*i +: 16] <= manual_drive_cmd_reg[i+2];
          endcase
        end
      end
    end
  end

  // Ramp engines and busy outputs
  for (genvar g = 0; g < 4; g++) begin : g_chan
    srhr_ramp_chan u_chan (
      .clk          (clk),
      .arst_n       (arst_n),
      .tick         (tick_reg),
      .ramp_en      (ramp_en_reg[g]),
      .sensor_units (sunits_reg[g]),
      .rate         (rate_reg[g]),
      .abort        (sensor_chg[g]),
      .load         (tgt_wr[g]),
      .load_val     (pwdata),
      .stop         (stop_req[g]),
      .bypass       (bypass_req[g]),
      .measured     (measured[32*g +: 32]),
      .eff_sp       (eff_sp[g]),
      .busy         (busy[g])
    );

    all_off_a: assert property ( // R14
      @(posedge clk) disable iff (!arst_n)
      all_off |=> range_out[2*g +: 2] == srhr_pkg::RANGE_OFF)
      else $error("all-off left an output on");

    fault_off_a: assert property ( // R12
      @(posedge clk) disable iff (!arst_n)
      temp_limit || input_err[g] || (power_lost && !puen_reg)
        |=> range_reg[g] == srhr_pkg::RANGE_OFF)
      else $error("fault did not force range off");

    chg_abort_a: assert property ( // R6
      @(posedge clk) disable iff (!arst_n)
      sensor_chg[g] && busy[g]
        |=> !ramp_en_reg[g] && range_reg[g] == srhr_pkg::RANGE_OFF)
      else $error("input change did not stop ramp and heater");
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ramp_busy <= 4'h0;
    end else begin
      ramp_busy <= busy;
    end
  end

  analog_range_a: assert property ( // R11
    @(posedge clk) disable iff (!arst_n)
    range_reg[2][1] == 1'b0 && range_reg[3][1] == 1'b0)
    else $error("analog output took a heater range");

  dac_off_a: assert property ( // R16
    @(posedge clk) disable iff (!arst_n)
    range_reg[2] == srhr_pkg::RANGE_OFF |=> dac_code[15:0] == 16'h8000)
    else $error("analog output not at zero volts when off");

endmodule // srhr_top

// ### tb/srhr_load_model.sv
/* Heater load and supply model: per-output temperature readings.
   Assumes the bench pulses cut to imitate a loss of mains. */
`timescale 1ns/1ns
module srhr_load_model (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Supply and heater drive
  input  wire logic         cut,
  input  wire logic [31:0]  drive,
  // Sensor side
  output logic      [127:0] measured,
  output logic              power_lost
);
  // Heaters warm their loads; outputs three and four sit at base
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      measured <= '0;
    end else begin
      measured <= {32'h2bf20, 32'h2bf20, 32'h2bf20 + 32'(drive[31:16]),
                   32'h2bf20 + 32'(drive[15:0])};
    end
  end
  // supply loss seen a cycle late
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) power_lost <= 1'b0;
    else power_lost <= cut;
  end
endmodule // srhr_load_model

// ### tb/srhr_top_bench.sv
/* Self-checking bench for the ramp and range block with a load model.
   Assumes short tick and bypass counts, set below. */
`timescale 1ns/1ns
module srhr_top_bench;
  localparam int BY = 10;
  logic         clk = 1'b0, arst_n = 1'b0, er, power_lost, cut = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready;
  logic         pslverr, temp_limit = 1'b0, all_off_key = 1'b0;
  logic         target_temperature_cmd_key = 1'b0, stop_key = 1'b0;
  logic [1:0]   shown_loop = '0;
  logic [3:0]   sensor_chg = '0, input_err = '0, ramp_busy;
  logic [7:0]   range_out;
  logic [31:0]  paddr = '0, pwdata = '0, prdata, q, e, m;
  logic [31:0]  pid_result = '0, warmup_code = '0, monitor_code = '0;
  logic [31:0]  heater_drive, dac_code, seed = 32'hbb3879ef;
  logic [127:0] measured;
  int           error_cnt = 0, total_checks = 0, cyc = 0, k;

  srhr_top #(.TICK_CYCLES(20), .BYPASS_CYCLES(BY)) dut (.*);
  srhr_load_model load (.clk(clk), .arst_n(arst_n), .cut(cut),
    .drive(heater_drive), .measured(measured), .power_lost(power_lost));

  // Clock of 100 ns
  initial forever #50 clk = ~clk;

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] scl(input logic [15:0] d, input int r);
    return r == 3 ? d : r == 2 ? d / 16'd10 : r == 1 ? d / 16'd100 : '0;
  endfunction
  function automatic logic [31:0] tg(input int n);
    return {24'h0, 4'(n + 1), srhr_pkg::TGT_OFS};
  endfunction
  function automatic logic [31:0] rc(input int n);
    return {24'h0, 4'(n + 1), srhr_pkg::RCFG_OFS};
  endfunction
  function automatic logic [31:0] oc(input int n);
    return {24'h0, 4'(n + 1), srhr_pkg::OCFG_OFS};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Effective setpoint of output zero
  task automatic rdeff();
    rd({24'h0, 4'h1, srhr_pkg::EFF_OFS});
  endtask
  // Bounded wait for output zero's ramp to end
  task automatic idle();
    @(posedge clk);
    for (k = 0; k < 2000 && ramp_busy[0] !== 1'b0; k++) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk(32'({range_out, ramp_busy}), 32'h0);
    chk(dac_code, 32'h80008000);
    rd(rc(0));
    chk(q, 32'h0);
    // Up then down, target off the step grid
    wr(rc(0), 32'h00010005);
    wr(tg(0), 32'd520);
    rd(rc(0));
    chk(32'(q[31]), 32'h1);
    idle();
    rdeff();
    chk(q, 32'd520);
    wr(tg(0), 32'd0);
    idle();
    rdeff();
    chk(q, 32'd0);
    $display("ramp test done");
    // Rate field, one value over the top
    for (int i = 0; i < 5; i++) begin
      e = (i == 0) ? 32'h3ff : xs();
      wr(rc(1), {22'h0, e[9:0]});
      rd(rc(1));
      chk(q, 32'(e[9:0] > 10'd1000 ? 10'd1000 : e[9:0]));
    end
    // Zero rate holds while busy stays set
    wr(rc(0), 32'h00010000);
    wr(tg(0), 32'd100);
    repeat (60) @(posedge clk);
    chk(32'(ramp_busy[0]), 32'h1);
    rdeff();
    chk(q, 32'd0);
    // Stop key freezes, new entry ramps on
    wr(rc(0), 32'h00010001);
    wr(tg(0), 32'd5000);
    stop_key <= 1'b1;
    @(posedge clk);
    stop_key <= 1'b0;
    rdeff();
    m = q;
    repeat (60) @(posedge clk);
    rdeff();
    chk(q, m);
    rd(rc(0));
    chk(32'(q[16]), 32'h1);
    wr(tg(0), m + 32'd30);
    idle();
    rdeff();
    chk(q, m + 32'd30);
    // Ramping off mid ramp holds the setpoint
    wr(tg(0), 32'd5000);
    repeat (50) @(posedge clk);
    wr(rc(0), 32'h1);
    rdeff();
    m = q;
    repeat (60) @(posedge clk);
    rdeff();
    chk(q, m);
    $display("ramp control test done");
    // Sensor units load directly, enable kept
    wr(oc(0), 32'h100);
    wr(rc(0), 32'h00010001);
    wr(tg(0), 32'd7000);
    rdeff();
    chk(q, 32'd7000);
    rd(rc(0));
    chk(32'(q[16]), 32'h1);
    // Input change mid ramp
    wr(oc(0), 32'h3);
    wr(tg(0), 32'd100);
    sensor_chg[0] <= 1'b1;
    @(posedge clk);
    sensor_chg[0] <= 1'b0;
    rd(rc(0));
    chk(32'({q[16], range_out[1:0]}), 32'h0);
    // Limit, input error and power loss in turn, then power loss with power-up on
    for (int i = 0; i < 4; i++) begin
      if (i == 3) wr(32'(srhr_pkg::CTRL_OFS), 32'h2);
      wr(oc(0), 32'h3);
      temp_limit <= (i == 0);
      input_err[0] <= (i == 1);
      cut <= (i > 1);
      repeat (3) @(posedge clk);
      temp_limit <= 1'b0;
      input_err <= '0;
      cut <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(range_out[1:0]), (i == 3) ? 32'h3 : 32'h0);
    end
    $display("shutdown test done");
    // Decade scaling; closed loop at high range
    m = xs() >> 1;
    e = xs() >> 28;
    pid_result <= e;
    for (int r = 0; r < 4; r++) begin
      wr(oc(0), {m[31:16], 6'h0, (r == 3), 9'(r)});
      repeat (3) @(posedge clk);
      chk(heater_drive, {16'h0, scl(m[31:16] + 16'(r / 3 * e), r)});
    end
    // Analog output three in each mode
    warmup_code <= xs();
    monitor_code <= xs();
    for (int md = 0; md < 3; md++) begin
      wr(oc(2), {m[31:16], 12'(md), 4'h3});
      rd(oc(2));
      chk(32'(q[1:0]), 32'h1);
      e = md == 0 ? m >> 16 : md == 1 ? warmup_code : monitor_code;
      chk(dac_code, {16'h8000, e[15:0]});
    end
    $display("drive test done");
    // All-off by register, then by key
    for (int i = 0; i < 2; i++) begin
      wr(oc(1), 32'h2);
      wr(oc(3), 32'h1);
      if (i == 0) wr(32'(srhr_pkg::CTRL_OFS), 32'h1);
      all_off_key <= (i == 1);
      repeat (2) @(posedge clk);
      all_off_key <= 1'b0;
      chk(32'(range_out), 32'h0);
    end
    apb(1'b1, 32'h100, 32'h0);
    chk(32'(er), 32'h1);
    // Held setpoint key loads the reading
    wr(tg(0), 32'd9000);
    target_temperature_cmd_key <= 1'b1;
    repeat (BY + 4) @(posedge clk);
    target_temperature_cmd_key <= 1'b0;
    rdeff();
    chk(q, 32'h2bf20);
    $display("all-off and bypass test done");
    end_of_test();
  end
endmodule // srhr_top_bench
